// >>> bench/tb_top.sv
// self-checking bench for the transmit backplane block
`timescale 1ns/1ps
`include "tbp_params.svh"
module tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic mux = 1'b0;
	logic p_en = 1'b0;
	logic p_de = 1'b1;
	logic p_pol = 1'b0;
	logic [9:0] p_bits = 10'h0c1;
	logic [7:0] rdata;
	logic [9:0] bidx;
	logic [4:0] fidx;
	logic sck, fs, sd, sig, ck_o, ck_oe, fp_o, fp_oe, bv, bo, so, su;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	tbp_sys_partner i_tbp_sys_partner (.en_i(p_en), .de_i(p_de), .pol_i(p_pol), .bits_i(p_bits),
		.sck_o(sck), .fs_o(fs), .sd_o(sd), .sig_o(sig));
	// short half period keeps master frames quick
	tbp_backplane #(.HALF_CYC(2), .FRAMES_PER_SF(3), .LINK_IDX(0)) i_tbp_backplane (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mux_mode_i(mux),
		.tx_link_sys_clock_i(sck), .tx_link_sys_clock_o(ck_o), .tx_link_sys_clock_oe_o(ck_oe),
		.tx_link_frame_pulse_i(fs), .tx_link_frame_pulse_o(fp_o), .tx_link_frame_pulse_oe_o(fp_oe),
		.tx_link_sys_data_i(sd), .tx_link_signaling_i(sig), .tx_shared_bus_clock_i(sck),
		.tx_shared_bus_frame_pulse_i(fs), .tx_shared_bus_data_i(sd), .tx_shared_bus_signaling_i(sig),
		.tx_bit_o(bo), .tx_sig_o(so), .tx_bit_valid_o(bv), .tx_bit_index_o(bidx),
		.tx_slot_used_o(su), .tx_frame_index_o(fidx));
	always #10 ref_clk_i = ~ref_clk_i;
	task automatic wrap_up;
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp, input string msg);
		compares++;
		if (got != exp) begin
			errors++;
			$display("MISMATCH %0t %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1;
		chkv({8'h00, rdata & m}, {8'h00, e}, "register");
	endtask
	function automatic logic slot_exp(input logic [1:0] m, input logic [9:0] b);
		logic [4:0] t;
		t = b[7:3];
		case (m)
			2'h1: return (t >= 1 && t <= 15) || (t >= 17 && t <= 25);
			2'h2: return t[1:0] != 2'h0;
			2'h3: return t >= 1 && t <= 24;
			default: return 1'b1;
		endcase
	endfunction
	task automatic t_regs;
		chkv({14'h0000, ck_oe, fp_oe}, 16'h0000, "slave enables");
		rd_chk(`TBP_OFS_OPT, 8'hff, `TBP_RST_OPT);
		rd_chk(`TBP_OFS_MODE, 8'hff, `TBP_RST_MODE);
		rd_chk(`TBP_OFS_BOFF, 8'hff, `TBP_RST_BOFF);
		wr_reg(`TBP_OFS_OPT, 8'hff);
		rd_chk(`TBP_OFS_OPT, 8'hff, 8'h3f);
		wr_reg(`TBP_OFS_MODE, 8'hff);
		rd_chk(`TBP_OFS_MODE, 8'hff, 8'h07);
		rd_chk(`TBP_OFS_STAT, 8'h03, 8'h00);
		wr_reg(`TBP_OFS_BOFF, 8'hff);
		rd_chk(`TBP_OFS_BOFF, 8'hff, 8'h08);
		wr_reg(10'h050, 8'h5a);
		rd_chk(10'h050, 8'hff, 8'h00);
		mux <= 1'b1;
		rd_chk(`TBP_OFS_STAT, 8'h03, 8'h02);
		mux <= 1'b0;
		wr_reg(`TBP_OFS_BOFF, 8'h00);
	endtask
	task automatic t_slave(input logic [7:0] opt, input logic [1:0] map, input logic [9:0] n);
		logic [9:0] prev;
		int wraps;
		wr_reg(`TBP_OFS_OPT, opt);
		wr_reg(`TBP_OFS_MODE, {5'h00, map, 1'b1});
		p_de <= opt[4];
		p_pol <= opt[1];
		p_bits <= n;
		p_en <= 1'b1;
		// alignment only settles once a frame pulse has been seen
		repeat (n * 8 + 40) @(posedge ref_clk_i);
		wraps = 0;
		prev = 10'h3ff;
		repeat (300) begin
			do begin
				@(posedge ref_clk_i);
				#1;
			end while (bv !== 1'b1);
			if (prev != 10'h3ff)
				chkv({6'h00, bidx}, {6'h00, (prev + 10'h001 == n) ? 10'h000 : prev + 10'h001}, "index");
			chkv({15'h0000, bo}, {15'h0000, bidx[0] ^ bidx[2]}, "data bit");
			chkv({15'h0000, so}, {15'h0000, bidx[1]}, "signal bit");
			chkv({15'h0000, su}, {15'h0000, slot_exp(map, bidx)}, "slot");
			wraps += (bidx === 10'h000);
			prev = bidx;
		end
		chkn(wraps > 0, 1, "frame wrap");
		p_en <= 1'b0;
	endtask
	task automatic t_master(input logic [7:0] opt, input int period, input int rises);
		int c, r, seen;
		logic act, prev_act, prev_ck;
		wr_reg(`TBP_OFS_OPT, opt);
		wr_reg(`TBP_OFS_MODE, 8'h00);
		repeat (4) @(posedge ref_clk_i);
		#1;
		chkv({14'h0000, ck_oe, fp_oe}, 16'h0003, "master enables");
		c = 0;
		r = 0;
		seen = 0;
		prev_act = 1'b1;
		prev_ck = ck_o;
		// the first pulse may belong to the old settings, so measure between the second and third
		while (seen < 3) begin
			@(posedge ref_clk_i);
			#1;
			act = fp_o ^ opt[1];
			if (act === 1'b1 && prev_act === 1'b0)
				seen++;
			if (seen == 2) begin
				c++;
				r += (ck_o === 1'b1 && prev_ck === 1'b0);
			end
			prev_act = act;
			prev_ck = ck_o;
		end
		chkn(c, period, "frame period");
		chkn(r, rises, "clock rises");
	endtask
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors = errors + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_slave(8'h18, 2'h0, 10'h0c1);
		t_slave(8'h02, 2'h1, 10'h100);
		t_slave(8'h10, 2'h2, 10'h100);
		t_slave(8'h0a, 2'h3, 10'h100);
		t_master(8'h18, 772, 193);
		t_master(8'h38, 772, 192);
		t_master(8'h1b, 2316, 579);
		wrap_up;
	end
endmodule

// >>> bench/tbp_sys_partner.sv
// system-side framer model driving the slave transmit pins
`timescale 1ns/1ps
module tbp_sys_partner (
	input wire logic en_i,
	input wire logic de_i,
	input wire logic pol_i,
	input wire logic [9:0] bits_i,
	output logic sck_o,
	output logic fs_o,
	output logic sd_o,
	output logic sig_o
);
	logic [9:0] bit_r;
	initial begin
		sck_o = 1'b0;
		bit_r = 10'h000;
		fs_o = 1'b0;
		sd_o = 1'b0;
		sig_o = 1'b0;
		#7;
		forever begin
			#80;
			// clock stands still while disabled
			if (en_i) begin
				sck_o = ~sck_o;
				// launch opposite the sampling edge so the line is settled when taken
				if (sck_o != de_i) begin
					bit_r = (bit_r + 10'h001 >= bits_i) ? 10'h000 : bit_r + 10'h001;
					fs_o = (bit_r == 10'h000) ^ pol_i;
					sd_o = bit_r[0] ^ bit_r[2];
					sig_o = bit_r[1];
				end
			end
		end
	end
endmodule

// >>> hw/tbp_backplane.sv
// transmit system-side backplane interface: registers, clock master/slave timing, bit and frame tracking
// Behaviour
// RULE_01 - master mode with gap set: no clock pulse during the framing bit
// RULE_02 - data-edge bit picks falling (0) or rising (1) edge for data sampling
// RULE_03 - frame-edge bit picks falling (0) or rising (1) edge for frame pulse
// RULE_04 - on shared bus, software programs edge, rate, polarity, type alike for links
// RULE_05 - slave E1-rate and shared bus: rate bit selects single or double clock
// RULE_06 - both links on first link's pins: software keeps rate bits equal
// RULE_07 - polarity bit: frame pulse active high at 0, active low at 1
// RULE_08 - type 0: frame pulse at every framing bit, first link on bus
// RULE_09 - type 1: frame pulse only at first framing bit of superframe
// RULE_10 - mapping field: T1 rate, standard E1, filler every four, continuous
// RULE_11 - sub-mode 0: device makes clock and frame pulse timing itself
// RULE_12 - sub-mode 1: system side supplies clock and frame pulse
// RULE_13 - double-rate clock: select bit picks first or second edge per bit
// RULE_14 - master drives clock and frame pulse pins; slave treats them as inputs
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "tbp_params.svh"
module tbp_backplane #(
	parameter int HALF_CYC = `TBP_HALF_CYC,
	parameter int FRAMES_PER_SF = 12,
	parameter int LINK_IDX = 0
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [`TBP_ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic mux_mode_i,
	input wire logic tx_link_sys_clock_i,
	output logic tx_link_sys_clock_o,
	output logic tx_link_sys_clock_oe_o,
	input wire logic tx_link_frame_pulse_i,
	output logic tx_link_frame_pulse_o,
	output logic tx_link_frame_pulse_oe_o,
	input wire logic tx_link_sys_data_i,
	input wire logic tx_link_signaling_i,
	input wire logic tx_shared_bus_clock_i,
	input wire logic tx_shared_bus_frame_pulse_i,
	input wire logic tx_shared_bus_data_i,
	input wire logic tx_shared_bus_signaling_i,
	output logic tx_bit_o,
	output logic tx_sig_o,
	output logic tx_bit_valid_o,
	output logic [9:0] tx_bit_index_o,
	output logic tx_slot_used_o,
	output logic [4:0] tx_frame_index_o
);
	logic [7:0] opt_r;
	logic [7:0] mode_reg_r;
	logic [7:0] boff_r;
	logic [7:0] pins_s;
	tbp_pkg::tbp_mode_t mode;
	tbp_pkg::tbp_map_t map;
	logic gap, de, fe, double_rate_clock_sel, frame_pulse_polarity, frame_pulse_type, edge_sel;
	logic s_clk, s_fp, s_dat, s_sig, s_clk_prev_r;
	logic [$clog2(HALF_CYC+1)-1:0] div_r;
	logic m_phase_r, m_rise, m_fall;
	logic rise_ev, fall_ev, data_ev, frame_ev, dbl, take, fp_act;
	logic half_r, pend_r, locked_r;
	logic [9:0] bit_r, bit_nxt, frame_len;
	logic [9:0] bit_cur;
	logic fp_hit;
	logic [4:0] frm_r;
	logic clk_out_r, fp_out_r;
	logic [6:0] slot;
	logic [4:0] ts;
	logic used;

	assign gap = opt_r[`TBP_OPT_GAP];
	assign de = opt_r[`TBP_OPT_DE];
	assign fe = opt_r[`TBP_OPT_FE];
	assign double_rate_clock_sel = opt_r[`TBP_OPT_CMS];
	assign frame_pulse_polarity = opt_r[`TBP_OPT_FRAME_PULSE_POLARITY];
	assign frame_pulse_type = opt_r[`TBP_OPT_FRAME_PULSE_TYPE];
	assign edge_sel = boff_r[`TBP_BOFF_EDGE];
	assign map = tbp_pkg::tbp_map_t'(mode_reg_r[`TBP_MODE_MAP_HI:`TBP_MODE_MAP_LO]);

	// shared bus always runs as slave; sub-mode only matters per link
	always_comb begin
		if (mux_mode_i)
			mode = tbp_pkg::TBP_MUX;
		else if (mode_reg_r[`TBP_MODE_SUB])
			mode = tbp_pkg::TBP_SLAVE; // see RULE_12
		else
			mode = tbp_pkg::TBP_MASTER; // see RULE_11
	end

	// register writes
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			opt_r <= `TBP_RST_OPT;
			mode_reg_r <= `TBP_RST_MODE;
			boff_r <= `TBP_RST_BOFF;
		end else if (ce_i && reg_wr_i) begin
			case (reg_addr_i)
				`TBP_OFS_OPT: opt_r <= reg_wdata_i & `TBP_OPT_MASK;
				`TBP_OFS_MODE: mode_reg_r <= reg_wdata_i & `TBP_MODE_MASK;
				`TBP_OFS_BOFF: boff_r <= reg_wdata_i & `TBP_BOFF_MASK;
				default: ;
			endcase
		end
	end

	// register reads, data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (reg_rd_i) begin
				case (reg_addr_i)
					`TBP_OFS_OPT: reg_rdata_o <= opt_r;
					`TBP_OFS_MODE: reg_rdata_o <= mode_reg_r;
					`TBP_OFS_BOFF: reg_rdata_o <= boff_r;
					`TBP_OFS_STAT: reg_rdata_o <= {3'h0, frm_r == 5'h00, pend_r, locked_r,
						mode == tbp_pkg::TBP_MUX, mode == tbp_pkg::TBP_MASTER};
					default: reg_rdata_o <= 8'h00;
				endcase
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// all pin inputs pass two flops; clock and data share the delay so they stay aligned
	tbp_sync #(.W(8)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({tx_shared_bus_signaling_i, tx_shared_bus_data_i, tx_shared_bus_frame_pulse_i,
			tx_shared_bus_clock_i, tx_link_signaling_i, tx_link_sys_data_i, tx_link_frame_pulse_i,
			tx_link_sys_clock_i}),
		.q_o(pins_s)
	);

	// on the shared bus both links read the same pins with their own copies of the options
	assign s_clk = (mode == tbp_pkg::TBP_MUX) ? pins_s[4] : pins_s[0]; // see RULE_04
	assign s_fp = (mode == tbp_pkg::TBP_MUX) ? pins_s[5] : pins_s[1];
	assign s_dat = (mode == tbp_pkg::TBP_MUX) ? pins_s[6] : pins_s[2];
	assign s_sig = (mode == tbp_pkg::TBP_MUX) ? pins_s[7] : pins_s[3];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			s_clk_prev_r <= 1'b0;
		else if (ce_i)
			s_clk_prev_r <= s_clk;
	end

	// master clock divider; the period is rounded down to whole cycles
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			div_r <= '0;
			m_phase_r <= 1'b0;
		end else if (ce_i && mode == tbp_pkg::TBP_MASTER) begin
			if (int'(div_r) == HALF_CYC - 1) begin
				div_r <= '0;
				m_phase_r <= !m_phase_r;
			end else begin
				div_r <= div_r + 1'b1;
			end
		end
	end

	assign m_rise = (mode == tbp_pkg::TBP_MASTER) && int'(div_r) == HALF_CYC - 1 && !m_phase_r;
	assign m_fall = (mode == tbp_pkg::TBP_MASTER) && int'(div_r) == HALF_CYC - 1 && m_phase_r;

	always_comb begin
		case (mode)
			tbp_pkg::TBP_MASTER: begin
				rise_ev = ce_i && m_rise;
				fall_ev = ce_i && m_fall;
			end
			tbp_pkg::TBP_SLAVE, tbp_pkg::TBP_MUX: begin
				rise_ev = ce_i && s_clk && !s_clk_prev_r;
				fall_ev = ce_i && !s_clk && s_clk_prev_r;
			end
			default: begin
				rise_ev = 1'b0;
				fall_ev = 1'b0;
			end
		endcase
	end

	assign data_ev = de ? rise_ev : fall_ev; // see RULE_02
	assign frame_ev = fe ? rise_ev : fall_ev; // see RULE_03
	assign fp_act = s_fp ^ frame_pulse_polarity; // see RULE_07
	// double rate only for slave at E1 rate or the shared bus
	assign dbl = double_rate_clock_sel && (mode == tbp_pkg::TBP_MUX || (mode == tbp_pkg::TBP_SLAVE && map != tbp_pkg::TBP_MAP_T1)); // see RULE_05
	assign take = data_ev && (!dbl || half_r == edge_sel); // see RULE_13

	always_comb begin
		if (mode == tbp_pkg::TBP_MUX)
			frame_len = 10'(`TBP_MUX_FRAME_BITS - 1);
		else if (mode == tbp_pkg::TBP_SLAVE && map != tbp_pkg::TBP_MAP_T1)
			frame_len = 10'(`TBP_E1_FRAME_BITS - 1);
		else
			frame_len = 10'(`TBP_T1_FRAME_BITS - 1);
	end

	// phase within a double-rate bit; realigned by the frame pulse
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			half_r <= 1'b0;
		else if (!dbl)
			half_r <= 1'b0;
		else if (frame_ev && fp_act && mode != tbp_pkg::TBP_MASTER)
			half_r <= data_ev ? 1'b1 : 1'b0; // see RULE_13
		else if (data_ev)
			half_r <= !half_r;
	end

	// a slave frame pulse marks the next sampled bit as the framing bit
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			pend_r <= 1'b0;
		else if (mode == tbp_pkg::TBP_MASTER)
			pend_r <= 1'b0;
		else if (take)
			pend_r <= 1'b0;
		else if (frame_ev && fp_act)
			pend_r <= 1'b1; // see RULE_03
	end

	assign fp_hit = (mode != tbp_pkg::TBP_MASTER) && (pend_r || (frame_ev && fp_act));
	// a pulse seen on the sampling edge itself makes this very sample the framing bit
	assign bit_cur = fp_hit ? 10'h000 : bit_r;

	always_comb begin
		if (bit_cur >= frame_len)
			bit_nxt = 10'h000;
		else
			bit_nxt = bit_cur + 10'h001;
	end

	// bit and frame position; a type-1 pulse also realigns the superframe
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bit_r <= 10'h000;
			frm_r <= 5'h00;
			locked_r <= 1'b0;
		end else if (take) begin
			bit_r <= bit_nxt;
			if (mode != tbp_pkg::TBP_MASTER && (pend_r || (frame_ev && fp_act))) begin
				locked_r <= 1'b1;
				if (frame_pulse_type)
					frm_r <= 5'h00; // see RULE_09
				else if (bit_r != 10'h000)
					frm_r <= (int'(frm_r) == FRAMES_PER_SF - 1) ? 5'h00 : frm_r + 5'h01; // see RULE_08
			end else if (bit_nxt == 10'h000) begin
				frm_r <= (int'(frm_r) == FRAMES_PER_SF - 1) ? 5'h00 : frm_r + 5'h01;
			end
			if (mode == tbp_pkg::TBP_MASTER)
				locked_r <= 1'b1;
		end else if (ce_i && mode == tbp_pkg::TBP_MASTER && !mode_reg_r[`TBP_MODE_SUB] && !locked_r) begin
			locked_r <= 1'b0;
		end
	end

	// master clock out, held low through the framing bit when gapped
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			clk_out_r <= 1'b0;
		else if (ce_i)
			clk_out_r <= m_rise ? !(gap && bit_r == 10'h000) : (m_phase_r && !m_fall && clk_out_r); // see RULE_01
	end

	// master frame pulse, updated on the chosen edge
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			fp_out_r <= 1'b0;
		else if (mode != tbp_pkg::TBP_MASTER)
			fp_out_r <= 1'b0;
		else if (frame_ev)
			fp_out_r <= (bit_r == 10'h000 && (!frame_pulse_type || frm_r == 5'h00)) ^ frame_pulse_polarity; // see RULE_09
	end

	// pins are driven only as master
	assign tx_link_sys_clock_o = clk_out_r;
	assign tx_link_frame_pulse_o = fp_out_r;
	assign tx_link_sys_clock_oe_o = (mode == tbp_pkg::TBP_MASTER); // see RULE_14
	assign tx_link_frame_pulse_oe_o = (mode == tbp_pkg::TBP_MASTER); // see RULE_14

	// slot occupancy for each mapping of T1 channels into an E1-rate frame
	assign slot = bit_cur[9:3];
	assign ts = (mode == tbp_pkg::TBP_MUX) ? slot[6:2] : slot[4:0];
	always_comb begin
		used = 1'b1;
		if (mode != tbp_pkg::TBP_MASTER) begin
			case (map) // see RULE_10
				tbp_pkg::TBP_MAP_T1: used = 1'b1;
				tbp_pkg::TBP_MAP_STD: used = (ts >= 5'h01 && ts <= 5'h0f) || (ts >= 5'h11 && ts <= 5'h19);
				tbp_pkg::TBP_MAP_FILL4: used = (ts[1:0] != 2'h0);
				tbp_pkg::TBP_MAP_CONT: used = (ts >= 5'h01 && ts <= 5'h18);
				default: used = 1'b0;
			endcase
		end
		// byte-interleaved bus: only this link's bytes count
		if (mode == tbp_pkg::TBP_MUX && int'(slot[1:0]) != LINK_IDX)
			used = 1'b0;
	end

	// sampled data out; data taken from the line input on the active edge
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_bit_o <= 1'b0;
			tx_sig_o <= 1'b0;
			tx_bit_valid_o <= 1'b0;
			tx_bit_index_o <= 10'h000;
			tx_slot_used_o <= 1'b0;
			tx_frame_index_o <= 5'h00;
		end else if (ce_i) begin
			tx_bit_valid_o <= take;
			if (take) begin
				tx_bit_o <= (mode == tbp_pkg::TBP_MASTER) ? pins_s[2] : s_dat; // see RULE_02
				tx_sig_o <= (mode == tbp_pkg::TBP_MASTER) ? pins_s[3] : s_sig;
				tx_bit_index_o <= bit_cur;
				tx_slot_used_o <= used;
				tx_frame_index_o <= frm_r;
			end
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	gap_clock_a: assert property ((mode == tbp_pkg::TBP_MASTER) && gap && bit_r == 10'h000 && ce_i
		&& $past(bit_r) == 10'h000 |=> !clk_out_r) else $error("clock pulsed during gapped framing bit"); // see RULE_01
	data_edge_a: assert property (take |-> (de ? rise_ev : fall_ev)) else $error("data sampled on wrong edge"); // see RULE_02
	frame_edge_a: assert property ((mode != tbp_pkg::TBP_MASTER) && frame_ev && fp_act && !take
		|=> pend_r) else $error("frame pulse not caught on chosen edge"); // see RULE_03
	pulse_polarity_a: assert property ((mode == tbp_pkg::TBP_MASTER) && frame_ev && bit_r == 10'h000 && !frame_pulse_type
		|=> fp_out_r == !frame_pulse_polarity) else $error("frame pulse polarity wrong"); // see RULE_07
	superframe_pulse_a: assert property ((mode == tbp_pkg::TBP_MASTER) && frame_ev && frame_pulse_type && frm_r != 5'h00
		|=> fp_out_r == frame_pulse_polarity) else $error("frame pulse outside first frame"); // see RULE_09
	double_rate_a: assert property (take && dbl |-> half_r == edge_sel) else $error("wrong edge of double clock"); // see RULE_13
	pin_drive_a: assert property ((mode != tbp_pkg::TBP_MASTER) |-> !tx_link_sys_clock_oe_o
		&& !tx_link_frame_pulse_oe_o) else $error("slave drives link pins"); // see RULE_14
	filler_map_a: assert property (take && (mode == tbp_pkg::TBP_SLAVE) && map == tbp_pkg::TBP_MAP_FILL4
		|=> tx_slot_used_o == (tx_bit_index_o[4:3] != 2'h0)) else $error("filler slot mapping wrong"); // see RULE_10
	master_tick_a: assert property ((mode == tbp_pkg::TBP_MASTER) && ce_i && m_rise
		|=> !m_rise [*2]) else $error("master clock edges too close"); // see RULE_11
	rate_window_a: assert property (rise_ev && dbl && de && !(frame_ev && fp_act) && (mode != tbp_pkg::TBP_MASTER)
		|=> half_r != $past(half_r)) else $error("double rate phase stuck"); // see RULE_05
endmodule

// >>> hw/tbp_params.svh
// register map, field positions, reset values and timing counts of the transmit backplane block
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH
`define TBP_ADDR_W 10
`define TBP_OFS_OPT 10'h042
`define TBP_OFS_MODE 10'h043
`define TBP_OFS_BOFF 10'h045
`define TBP_OFS_STAT 10'h04f
`define TBP_RST_OPT 8'h00
`define TBP_RST_MODE 8'h01
`define TBP_RST_BOFF 8'h00
`define TBP_OPT_FRAME_PULSE_TYPE 0
`define TBP_OPT_FRAME_PULSE_POLARITY 1
`define TBP_OPT_CMS 2
`define TBP_OPT_FE 3
`define TBP_OPT_DE 4
`define TBP_OPT_GAP 5
`define TBP_OPT_MASK 8'h3f
`define TBP_MODE_SUB 0
`define TBP_MODE_MAP_LO 1
`define TBP_MODE_MAP_HI 2
`define TBP_MODE_MASK 8'h07
`define TBP_BOFF_EDGE 3
`define TBP_BOFF_MASK 8'h08
`define TBP_CLK_NS 20
`define TBP_T1_BIT_NS 648
`define TBP_HALF_CYC ((`TBP_T1_BIT_NS / 2) / `TBP_CLK_NS)
`define TBP_T1_FRAME_BITS 193
`define TBP_E1_FRAME_BITS 256
`define TBP_MUX_FRAME_BITS 1024
`endif

// >>> hw/tbp_pkg.sv
// types shared by the transmit backplane block
package tbp_pkg;
	typedef enum logic [1:0] {TBP_MASTER, TBP_SLAVE, TBP_MUX} tbp_mode_t;
	typedef enum logic [1:0] {TBP_MAP_T1, TBP_MAP_STD, TBP_MAP_FILL4, TBP_MAP_CONT} tbp_map_t;
endpackage

// >>> hw/tbp_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module tbp_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
